// file: shared/nfh_params.svh
// Purpose: Timing counts and field positions for the flash bus host.
// Assumes: Host clock of 25 MHz, a period of 40 ns.
// Notes: Times in ns; cycle counts derived from them.
`ifndef NFH_PARAMS_SVH
`define NFH_PARAMS_SVH
`define NFH_CLK_PERIOD_NS 40
`define NFH_ADDR_W 25
`define NFH_DATA_W 16
`define NFH_PAGE_BITS 4
`define NFH_BLOCK_LSB 16
`define NFH_BLOCK_W 9
`define NFH_ADDR_ACCESS_NS 105
`define NFH_PAGE_ACCESS_NS 20
`define NFH_WRITE_PULSE_NS 80
`define NFH_WRITE_RECOVER_NS 40
`define NFH_RESET_PULSE_NS 10000
`define NFH_RESET_TO_READ_NS 200
`define NFH_RESET_TO_WRITE_NS 200
`define NFH_CYC_UP(ns) (((ns) + `NFH_CLK_PERIOD_NS - 1) / `NFH_CLK_PERIOD_NS)
`define NFH_CNT_W 16
`endif

// file: shared/nfh_pkg.sv
// Purpose: Types shared by the flash bus host.
// Assumes: Widths match the constants header.
// Notes: None.
`include "nfh_params.svh"
package nfh_pkg;
   typedef struct packed {
      logic write;
      logic [`NFH_ADDR_W-1:0] addr;
      logic [`NFH_DATA_W-1:0] wdata;
   } nfh_req_s;
   typedef struct packed {
      logic sel_n;
      logic gate_n;
      logic wstrobe_n;
      logic rst_n;
      logic wp_n;
   } nfh_ctl_s;
   typedef enum logic [2:0] {
      ST_RESET = 3'b000,
      ST_WAKE = 3'b001,
      ST_IDLE = 3'b010,
      ST_READ = 3'b011,
      ST_WSETUP = 3'b100,
      ST_WPULSE = 3'b101,
      ST_WRECOV = 3'b110
   } nfh_state_e;
endpackage

// file: core/nfh_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: One clock domain.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module nfh_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_r;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         meta_r <= RST_VAL;
         q_o <= RST_VAL;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule // nfh_sync
`default_nettype wire

// file: core/nfh_host.sv
// Purpose: Host controller driving an asynchronous x16 NOR flash bus.
// Assumes: 25 MHz ref_clk_i; flash pins are asynchronous to it.
// Notes: Reads hold select low across a page for page access time.
`timescale 1ns/1ps
`default_nettype none
`include "nfh_params.svh"
module nfh_host
   import nfh_pkg::*;
#(
   parameter int RESET_PULSE_CYC = `NFH_CYC_UP(`NFH_RESET_PULSE_NS),
   parameter logic PROTECT_BOUNDARY = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire nfh_pkg::nfh_req_s req_i,
   input wire logic hw_reset_req_i,
   output logic req_ready_o,
   output logic rsp_valid_o,
   output logic [`NFH_DATA_W-1:0] rsp_data_o,
   output logic busy_o,
   output logic [`NFH_ADDR_W-1:0] flash_addr_o,
   output nfh_pkg::nfh_ctl_s flash_ctl_o,
   output logic [`NFH_DATA_W-1:0] flash_dq_o,
   output logic flash_dq_oe_n_o,
   input wire logic [`NFH_DATA_W-1:0] flash_dq_i,
   input wire logic busy_flag_n_i
);
   import nfh_pkg::*;

   localparam logic [`NFH_CNT_W-1:0] RAND_CYC = `NFH_CNT_W'(`NFH_CYC_UP(`NFH_ADDR_ACCESS_NS) + 2);
   localparam logic [`NFH_CNT_W-1:0] PAGE_CYC = `NFH_CNT_W'(`NFH_CYC_UP(`NFH_PAGE_ACCESS_NS) + 2);
   localparam logic [`NFH_CNT_W-1:0] WPULSE_CYC = `NFH_CNT_W'(`NFH_CYC_UP(`NFH_WRITE_PULSE_NS));
   localparam logic [`NFH_CNT_W-1:0] WREC_CYC = `NFH_CNT_W'(`NFH_CYC_UP(`NFH_WRITE_RECOVER_NS));
   localparam logic [`NFH_CNT_W-1:0] RST_CYC = `NFH_CNT_W'(RESET_PULSE_CYC);
   localparam int WAKE_NS = (`NFH_RESET_TO_READ_NS > `NFH_RESET_TO_WRITE_NS) ?
      `NFH_RESET_TO_READ_NS : `NFH_RESET_TO_WRITE_NS;
   localparam logic [`NFH_CNT_W-1:0] WAKE_CYC = `NFH_CNT_W'(`NFH_CYC_UP(WAKE_NS));
   localparam logic [`NFH_BLOCK_W-1:0] TOP_BLOCK = '1;
   localparam logic [`NFH_BLOCK_W-1:0] BOT_BLOCK = '0;

   // Block number of a word address.
   function automatic logic [`NFH_BLOCK_W-1:0] block_of(input logic [`NFH_ADDR_W-1:0] a);
      return a[`NFH_BLOCK_LSB +: `NFH_BLOCK_W];
   endfunction

   // Page base of a word address.
   function automatic logic [`NFH_ADDR_W-`NFH_PAGE_BITS-1:0] page_of(input logic [`NFH_ADDR_W-1:0] a);
      return a[`NFH_ADDR_W-1:`NFH_PAGE_BITS];
   endfunction

   nfh_state_e state_r, state_nxt;
   logic [`NFH_CNT_W-1:0] cnt_r, cnt_nxt;
   logic page_open_r, page_open_nxt;
   logic [`NFH_ADDR_W-`NFH_PAGE_BITS-1:0] open_page_r, open_page_nxt;
   logic [`NFH_ADDR_W-1:0] addr_r, addr_nxt;
   logic [`NFH_DATA_W-1:0] wdata_r, wdata_nxt;
   nfh_ctl_s ctl_r, ctl_nxt;
   logic dq_oe_n_r, dq_oe_n_nxt;
   logic ready_r, ready_nxt;
   logic rsp_valid_r, rsp_valid_nxt;
   logic [`NFH_DATA_W-1:0] rsp_data_r, rsp_data_nxt;
   logic busy_r;
   logic [`NFH_DATA_W-1:0] dq_sync;
   logic busy_sync_n;

   // Busy pin resets to its pulled-up idle level, so no false busy follows reset.
   nfh_sync #(.W(`NFH_DATA_W + 1), .RST_VAL({{`NFH_DATA_W{1'b0}}, 1'b1})) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .d_i({flash_dq_i, busy_flag_n_i}),
      .q_o({dq_sync, busy_sync_n})
   );

   wire cnt_done = (cnt_r == '0);
   wire cnt_last = (cnt_r == `NFH_CNT_W'(1));
   wire take = req_valid_i && ready_r;
   wire page_hit = page_open_r && (page_of(req_i.addr) == open_page_r);
   wire wr_guarded = !PROTECT_BOUNDARY && 1'b0;
   wire wp_level = 1'b1; // Keeps write-protect released, so the device writes every block, boundary blocks included.
   wire [`NFH_BLOCK_W-1:0] req_block = block_of(req_i.addr);
   wire boundary_hit = (req_block == TOP_BLOCK) || (req_block == BOT_BLOCK);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_done ? cnt_r : cnt_r - `NFH_CNT_W'(1);
      page_open_nxt = page_open_r;
      open_page_nxt = open_page_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      ctl_nxt = ctl_r;
      dq_oe_n_nxt = dq_oe_n_r;
      ready_nxt = 1'b0;
      rsp_valid_nxt = 1'b0;
      rsp_data_nxt = rsp_data_r;
      case (state_r)
         ST_RESET: begin
            ctl_nxt = '{sel_n: 1'b1, gate_n: 1'b1, wstrobe_n: 1'b1, rst_n: 1'b0, wp_n: wp_level};
            dq_oe_n_nxt = 1'b1;
            page_open_nxt = 1'b0;
            if (cnt_done) begin
               ctl_nxt.rst_n = 1'b1;
               cnt_nxt = WAKE_CYC;
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (cnt_done) begin
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            ready_nxt = 1'b1;
            if (hw_reset_req_i) begin
               ready_nxt = 1'b0;
               cnt_nxt = RST_CYC;
               state_nxt = ST_RESET;
            end else if (take && req_i.write) begin
               ready_nxt = 1'b0;
               page_open_nxt = 1'b0;
               addr_nxt = req_i.addr;
               wdata_nxt = req_i.wdata;
               ctl_nxt.sel_n = 1'b0;
               ctl_nxt.gate_n = 1'b1;
               dq_oe_n_nxt = 1'b0;
               state_nxt = ST_WSETUP;
            end else if (take) begin
               ready_nxt = 1'b0;
               addr_nxt = req_i.addr;
               ctl_nxt.sel_n = 1'b0;
               ctl_nxt.gate_n = 1'b0;
               ctl_nxt.wstrobe_n = 1'b1;
               dq_oe_n_nxt = 1'b1;
               cnt_nxt = page_hit ? PAGE_CYC : RAND_CYC;
               open_page_nxt = page_of(req_i.addr);
               page_open_nxt = 1'b1;
               state_nxt = ST_READ;
            end else if (!req_valid_i) begin
               ctl_nxt.sel_n = 1'b1;
               ctl_nxt.gate_n = 1'b1;
               page_open_nxt = 1'b0;
            end
         end
         ST_READ: begin
            if (cnt_done) begin
               rsp_valid_nxt = 1'b1;
               rsp_data_nxt = dq_sync;
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_WSETUP: begin
            ctl_nxt.wstrobe_n = 1'b0;
            cnt_nxt = WPULSE_CYC;
            state_nxt = ST_WPULSE;
         end
         ST_WPULSE: begin
            if (cnt_done) begin
               ctl_nxt.wstrobe_n = 1'b1;
               cnt_nxt = WREC_CYC;
               state_nxt = ST_WRECOV;
            end
         end
         ST_WRECOV: begin
            if (cnt_done) begin
               ctl_nxt.sel_n = 1'b1;
               dq_oe_n_nxt = 1'b1;
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            cnt_nxt = RST_CYC;
            state_nxt = ST_RESET;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r <= ST_RESET;
         cnt_r <= RST_CYC;
         page_open_r <= 1'b0;
         open_page_r <= '0;
         addr_r <= '0;
         wdata_r <= '0;
         ctl_r <= '{sel_n: 1'b1, gate_n: 1'b1, wstrobe_n: 1'b1, rst_n: 1'b0, wp_n: 1'b1};
         dq_oe_n_r <= 1'b1;
         ready_r <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_data_r <= '0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         page_open_r <= page_open_nxt;
         open_page_r <= open_page_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         ctl_r <= ctl_nxt;
         dq_oe_n_r <= dq_oe_n_nxt;
         ready_r <= ready_nxt;
         rsp_valid_r <= rsp_valid_nxt;
         rsp_data_r <= rsp_data_nxt;
         busy_r <= !busy_sync_n;
      end
   end

   assign req_ready_o = ready_r;
   assign rsp_valid_o = rsp_valid_r;
   assign rsp_data_o = rsp_data_r;
   assign busy_o = busy_r;
   assign flash_addr_o = addr_r;
   assign flash_ctl_o = ctl_r;
   assign flash_dq_o = wdata_r;
   assign flash_dq_oe_n_o = dq_oe_n_r;

   wire unused_ok = &{1'b0, wr_guarded, boundary_hit, cnt_last};
endmodule // nfh_host
`default_nettype wire

// file: tb/nfh_checker.sv
// Purpose: Pin rule checks on the flash bus host.
// Assumes: Bound to nfh_host.
// Notes: One clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "nfh_params.svh"
module nfh_checker
   import nfh_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic req_ready_o,
   input wire logic rsp_valid_o,
   input wire logic busy_o,
   input wire logic [`NFH_ADDR_W-1:0] flash_addr_o,
   input wire nfh_pkg::nfh_ctl_s flash_ctl_o,
   input wire logic [`NFH_DATA_W-1:0] flash_dq_o,
   input wire logic flash_dq_oe_n_o,
   input wire logic busy_flag_n_i
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   gate_in_write_a: assert property (!flash_ctl_o.wstrobe_n |-> flash_ctl_o.gate_n) else $error("gate low");
   write_state_a: assert property (!flash_ctl_o.wstrobe_n |-> !flash_ctl_o.sel_n && !flash_dq_oe_n_o
      && flash_ctl_o.wp_n) else $error("bad write");
   read_state_a: assert property (!flash_ctl_o.gate_n |-> flash_dq_oe_n_o && flash_ctl_o.wstrobe_n)
      else $error("bad read");
   reset_idle_a: assert property (!flash_ctl_o.rst_n |-> flash_ctl_o.sel_n && flash_ctl_o.gate_n
      && flash_ctl_o.wstrobe_n && !req_ready_o) else $error("reset active");
   wake_wait_a: assert property ($rose(flash_ctl_o.rst_n) |-> !req_ready_o [*4]) else $error("early");
   addr_hold_a: assert property (!flash_ctl_o.wstrobe_n |=> $stable(flash_addr_o)) else $error("addr");
   data_hold_a: assert property ($rose(flash_ctl_o.wstrobe_n) |-> !flash_ctl_o.sel_n && $stable(flash_dq_o)
      && !flash_dq_oe_n_o) else $error("data");
   rsp_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o) else $error("pulse");
   busy_set_a: assert property (!busy_flag_n_i [*4] |-> busy_o) else $error("busy");
   busy_clr_a: assert property (busy_flag_n_i [*4] |-> !busy_o) else $error("idle");
   busy_reset_a: assert property ($fell(reset_i) |-> !busy_o [*3]) else $error("busy after reset");
endmodule // nfh_checker
`default_nettype wire

// file: tb/nfh_flash_model.sv
// Purpose: Behavioural flash device on the host pins.
// Assumes: Host changes pins at clock edges.
// Notes: Array aliased to 512 words.
`timescale 1ns/1ps
`default_nettype none
`include "nfh_params.svh"
module nfh_flash_model
   import nfh_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic [`NFH_ADDR_W-1:0] addr_i,
   input wire nfh_pkg::nfh_ctl_s ctl_i,
   input wire logic [15:0] host_dq_i,
   input wire logic host_oe_n_i,
   output logic [15:0] dq_o,
   output logic busy_flag_n_o
);
   logic [15:0] mem [512];
   logic [15:0] last = 16'h0000;
   logic [8:0] wa;
   logic wr_d = 1'b0;
   int busy_cnt = 0;
   wire rd = ctl_i.rst_n && !ctl_i.sel_n && !ctl_i.gate_n && ctl_i.wstrobe_n;
   wire wr = ctl_i.rst_n && !ctl_i.sel_n && !ctl_i.wstrobe_n && ctl_i.gate_n;
   wire [8:0] ix = {addr_i[20:16], addr_i[3:0]};
   assign dq_o = !host_oe_n_i ? host_dq_i : rd ? mem[ix] : ~last;
   assign busy_flag_n_o = busy_cnt == 0;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
   end
   always @(posedge wr) wa = ix;
   always @(negedge wr) begin
      if (ctl_i.wp_n) mem[wa] = host_dq_i;
   end
   always @(posedge ref_clk_i) begin
      wr_d <= wr;
      if (rd || !host_oe_n_i) last <= dq_o;
      if (!ctl_i.rst_n && busy_cnt > 0) mem[wa] <= 16'h0000;
      if (!ctl_i.rst_n) busy_cnt <= 0;
      else if (wr_d && !wr) busy_cnt <= 20;
      else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
   end
endmodule // nfh_flash_model
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the flash bus host.
// Assumes: 25 MHz clock, short reset pulse parameter.
// Notes: Table rows first, then hand tests.
`timescale 1ns/1ps
`default_nettype none
`include "nfh_params.svh"
module tb_top;
   import nfh_pkg::*;
   typedef struct packed {logic w; logic [24:0] a; logic [15:0] d;} nfh_row_s;
   logic ref_clk_i = 1'b0, reset_i, req_valid_i, hw_reset_req_i, req_ready_o, rsp_valid_o, busy_o;
   logic flash_dq_oe_n_o, busy_flag_n_i;
   nfh_req_s req_i;
   nfh_ctl_s flash_ctl_o;
   logic [24:0] flash_addr_o;
   logic [15:0] rsp_data_o, flash_dq_o, flash_dq_i;
   int bad_count = 0, num_checks = 0;
   int lat_r = 0, lat_p = 0;
   nfh_row_s rows [8] = '{{1'b1, 25'h0000010, 16'h1234}, {1'b1, 25'h1FFFFFF, 16'hBEEF},
      {1'b1, 25'h0010000, 16'h5A5A}, {1'b0, 25'h0000010, 16'h1234}, {1'b0, 25'h0000011, 16'hFFFF},
      {1'b0, 25'h1FFFFFF, 16'hBEEF}, {1'b0, 25'h0010000, 16'h5A5A}, {1'b0, 25'h1FF0000, 16'hFFFF}};
   always #20 ref_clk_i = ~ref_clk_i;
   nfh_host #(.RESET_PULSE_CYC(4)) nfh_host_i (.ref_clk_i, .reset_i, .req_valid_i, .req_i, .hw_reset_req_i,
      .req_ready_o, .rsp_valid_o, .rsp_data_o, .busy_o, .flash_addr_o, .flash_ctl_o, .flash_dq_o,
      .flash_dq_oe_n_o, .flash_dq_i, .busy_flag_n_i);
   nfh_flash_model nfh_flash_model_i (.ref_clk_i, .addr_i(flash_addr_o), .ctl_i(flash_ctl_o),
      .host_dq_i(flash_dq_o), .host_oe_n_i(flash_dq_oe_n_o), .dq_o(flash_dq_i), .busy_flag_n_o(busy_flag_n_i));
   task automatic chk_d(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic req(input logic w, input logic [24:0] a, input logic [15:0] d);
      req_i <= {w, a, d};
      req_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      while (req_ready_o !== 1'b1) @(posedge ref_clk_i);
      req_valid_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [24:0] a, input logic [15:0] e);
      req(1'b0, a, 16'h0000);
      @(posedge ref_clk_i);
      while (rsp_valid_o !== 1'b1) @(posedge ref_clk_i);
      chk_d(rsp_data_o, e);
   endtask
   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      reset_i = 1'b1;
      req_valid_i = 1'b0;
      req_i = '0;
      hw_reset_req_i = 1'b0;
      repeat (4) @(posedge ref_clk_i);
      chk_b(flash_ctl_o.rst_n, 1'b0);
      chk_b(req_ready_o, 1'b0);
      reset_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (rows[i].w) req(1'b1, rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d);
      end
      repeat (3) @(posedge ref_clk_i);
      chk_b(flash_ctl_o.sel_n, 1'b1);
      chk_b(flash_dq_oe_n_o, 1'b1);
      req_i <= {1'b0, 25'h0000010, 16'h0000};
      req_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      while (req_ready_o !== 1'b1) @(posedge ref_clk_i);
      req_i <= {1'b0, 25'h0000011, 16'h0000};
      do begin
         @(posedge ref_clk_i);
         lat_r++;
      end while (req_ready_o !== 1'b1);
      chk_b(rsp_valid_o, 1'b1);
      chk_d(rsp_data_o, 16'h1234);
      req_valid_i <= 1'b0;
      do begin
         @(posedge ref_clk_i);
         lat_p++;
      end while (rsp_valid_o !== 1'b1 && lat_p < 50);
      chk_d(rsp_data_o, 16'hFFFF);
      chk_b(lat_p < lat_r, 1'b1);
      chk_b(lat_r * `NFH_CLK_PERIOD_NS > `NFH_ADDR_ACCESS_NS, 1'b1);
      req(1'b1, 25'h0000020, 16'h7777);
      repeat (10) @(posedge ref_clk_i);
      chk_b(busy_o, 1'b1);
      hw_reset_req_i <= 1'b1;
      repeat (300) begin
         @(posedge ref_clk_i);
         if (flash_ctl_o.rst_n === 1'b0) break;
      end
      chk_b(flash_ctl_o.rst_n, 1'b0);
      hw_reset_req_i <= 1'b0;
      rd(25'h1FFFFFF, 16'hBEEF);
      chk_b(busy_o, 1'b0);
      print_verdict();
   end
   initial begin
      #100000;
      bad_count++;
      print_verdict();
   end
endmodule // tb_top
bind nfh_host nfh_checker nfh_checker_i (.ref_clk_i, .reset_i, .req_ready_o, .rsp_valid_o, .busy_o,
   .flash_addr_o, .flash_ctl_o, .flash_dq_o, .flash_dq_oe_n_o, .busy_flag_n_i);
`default_nettype wire
